// *** trig_delay_pkg.sv ***
// constants and types for the trigger delay qualifier
package trig_delay_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int SRC_N = 32'h0000_0004;
  localparam int SRC_W = 32'h0000_0002;
  localparam int EVT_W = 32'h0000_0014;
  localparam int WAIT_W = 32'h0000_0020;
  localparam int DLY_W = 32'h0000_0040;
  localparam int STEP_W = 32'h0000_0020;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 32'h017D_7840;
  localparam int unsigned NS_PER_S = 32'h3B9A_CA00;
  localparam int unsigned CLK_PERIOD_NS = NS_PER_S / CLK_HZ;
  localparam int unsigned AUTO_TIMEOUT_MS = 32'h0000_0032;
  localparam int unsigned MS_PER_S = 32'h0000_03E8;
  localparam int unsigned AUTO_TIMEOUT_CYCLES = AUTO_TIMEOUT_MS * (CLK_HZ / MS_PER_S);
  localparam int AUTO_W = 32'h0000_0018;

  // ---------------------------------------------------------------
  // trigger modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_EDGE = 2'h0,
    MODE_EVENT = 2'h1,
    MODE_TIME = 2'h2
  } trig_mode_t;

  // ---------------------------------------------------------------
  // sweep speed codes and timebase delay limits, in ns
  // ---------------------------------------------------------------
  localparam logic [1:0] SPEED_500NS = 2'h0;
  localparam logic [1:0] SPEED_1S = 2'h1;
  localparam logic signed [63:0] LIM_POS_500NS = 64'h0000_0000_5F5E_1000;
  localparam logic signed [63:0] LIM_NEG_500NS = 64'h0000_0000_0BEB_C200;
  localparam logic signed [63:0] LIM_POS_1S = 64'h0002_21B2_62DD_8000;
  localparam logic signed [63:0] LIM_NEG_1S = 64'h0000_0002_540B_E400;
  localparam logic [63:0] DELAY_RESET = 64'h0000_0000_0000_0000;

endpackage

// *** trigger_delay_qualifier.sv ***
// trigger delay qualifier: edge, event and time delayed triggers, timebase delay, auto sweep
// Summary of operation
// - event mode triggers on final counted edge
// - time mode waits, then triggers next edge
// - no requalify until wait interval elapsed
// - auto sweep starts after 50 ms silence
// - negative delay before trigger, positive after
// - timebase delay measured from generated trigger
// - out-of-range delay clamped and error flagged
// - delay limits depend on sweep speed
// - clockwise decreases delay, counterclockwise increases
`timescale 1ns/1ps
module trigger_delay_qualifier #(
  parameter int unsigned AUTO_TIMEOUT_CYCLES = trig_delay_pkg::AUTO_TIMEOUT_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // conditioned trigger inputs
  input wire logic [trig_delay_pkg::SRC_N-1:0] trig_in,
  // trigger configuration
  input wire logic [1:0] trig_mode,
  input wire logic [trig_delay_pkg::SRC_W-1:0] qual_src,
  input wire logic qual_neg,
  input wire logic [trig_delay_pkg::SRC_W-1:0] edge_src,
  input wire logic edge_neg,
  input wire logic [trig_delay_pkg::EVT_W-1:0] event_count,
  input wire logic [trig_delay_pkg::WAIT_W-1:0] wait_cycles,
  input wire logic auto_sweep,
  // timebase delay control
  input wire logic [1:0] speed_sel,
  input wire logic signed [trig_delay_pkg::DLY_W-1:0] delay_req,
  input wire logic delay_load,
  input wire logic knob_step,
  input wire logic knob_cw,
  input wire logic [trig_delay_pkg::STEP_W-1:0] knob_step_ns,
  // results
  output logic trig_out,
  output logic sweep_start,
  output logic window_start,
  output logic window_pre,
  output logic signed [trig_delay_pkg::DLY_W-1:0] delay_value,
  output logic delay_err,
  output logic delay_busy
);

  typedef enum logic [3:0] {
    ST_ARM = 4'b0001,
    ST_COUNT = 4'b0010,
    ST_TIMING = 4'b0100,
    ST_FIRE = 4'b1000
  } state_t;

  // ---------------------------------------------------------------
  // input synchronisers and edge detect
  // ---------------------------------------------------------------
  logic [trig_delay_pkg::SRC_N-1:0] s1_q;
  logic [trig_delay_pkg::SRC_N-1:0] s2_q;
  logic [trig_delay_pkg::SRC_N-1:0] s3_q;
  logic [trig_delay_pkg::SRC_N-1:0] stable_q;
  logic [trig_delay_pkg::SRC_N-1:0] rise;
  logic [trig_delay_pkg::SRC_N-1:0] fall;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= trig_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < trig_delay_pkg::SRC_N; gi++) begin : g_edge
      // a level counts only once two stages agree
      always_ff @(posedge ref_clk) begin
        if (!nrst) begin
          stable_q[gi] <= 1'b0;
        end else if (s2_q[gi] == s3_q[gi]) begin
          stable_q[gi] <= s3_q[gi];
        end
      end
      assign rise[gi] = s2_q[gi] & s3_q[gi] & ~stable_q[gi];
      assign fall[gi] = ~s2_q[gi] & ~s3_q[gi] & stable_q[gi];
    end
  endgenerate

  logic qual_hit;
  logic edge_hit;
  assign qual_hit = qual_neg ? fall[qual_src] : rise[qual_src];
  assign edge_hit = edge_neg ? fall[edge_src] : rise[edge_src];

  // ---------------------------------------------------------------
  // trigger sequencer
  // ---------------------------------------------------------------
  state_t state_q;
  logic [1:0] mode_q;
  logic [trig_delay_pkg::EVT_W-1:0] cnt_q;
  logic [trig_delay_pkg::WAIT_W-1:0] wait_q;
  logic [trig_delay_pkg::EVT_W-1:0] count_last;
  logic wait_done;
  logic trig_fire;
  logic trig_out_q;

  // a zero count behaves as one
  assign count_last = (event_count == '0) ? '0 : event_count - 20'h0_0001;
  assign wait_done = (wait_q + 32'h0000_0001) >= wait_cycles;

  always_comb begin
    trig_fire = 1'b0;
    case (state_q)
      ST_ARM: trig_fire = (mode_q == trig_delay_pkg::MODE_EDGE) && edge_hit;
      ST_COUNT: trig_fire = edge_hit && (cnt_q == count_last);
      ST_FIRE: trig_fire = edge_hit;
      default: trig_fire = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      mode_q <= trig_delay_pkg::MODE_EDGE;
    end else begin
      mode_q <= trig_mode;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_q <= ST_ARM;
      cnt_q <= '0;
      wait_q <= '0;
    end else if (trig_mode != mode_q) begin
      state_q <= ST_ARM;
    end else begin
      case (state_q)
        ST_ARM: begin
          if (qual_hit && mode_q == trig_delay_pkg::MODE_EVENT) begin
            state_q <= ST_COUNT;
            cnt_q <= '0;
          end else if (qual_hit && mode_q == trig_delay_pkg::MODE_TIME) begin
            state_q <= ST_TIMING;
            wait_q <= '0;
          end
        end
        ST_COUNT: begin
          if (trig_fire) begin
            state_q <= ST_ARM;
          end else if (edge_hit) begin
            cnt_q <= cnt_q + 20'h0_0001;
          end
        end
        ST_TIMING: begin
          // qualifying edges are ignored until the wait is over
          wait_q <= wait_q + 32'h0000_0001;
          if (wait_done) begin
            state_q <= ST_FIRE;
          end
        end
        ST_FIRE: begin
          if (trig_fire) begin
            state_q <= ST_ARM;
          end
        end
        default: state_q <= ST_ARM;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      trig_out_q <= 1'b0;
    end else begin
      trig_out_q <= trig_fire;
    end
  end

  assign trig_out = trig_out_q;
  assign delay_busy = (state_q != ST_ARM);

  // ---------------------------------------------------------------
  // sweep start and auto timeout
  // ---------------------------------------------------------------
  logic [trig_delay_pkg::AUTO_W-1:0] auto_cnt_q;
  logic auto_fire;
  logic sweep_q;

  assign auto_fire = auto_sweep &&
    (auto_cnt_q == trig_delay_pkg::AUTO_W'(AUTO_TIMEOUT_CYCLES - 1));

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      auto_cnt_q <= '0;
    end else if (!auto_sweep || trig_fire || auto_fire) begin
      auto_cnt_q <= '0;
    end else begin
      auto_cnt_q <= auto_cnt_q + 24'h00_0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sweep_q <= 1'b0;
    end else begin
      sweep_q <= trig_fire || auto_fire;
    end
  end

  assign sweep_start = sweep_q;

  // ---------------------------------------------------------------
  // timebase delay value with clamping
  // ---------------------------------------------------------------
  logic signed [trig_delay_pkg::DLY_W-1:0] delay_q;
  logic signed [trig_delay_pkg::DLY_W-1:0] delay_raw;
  logic signed [trig_delay_pkg::DLY_W-1:0] lim_pos;
  logic signed [trig_delay_pkg::DLY_W-1:0] lim_neg;
  logic signed [trig_delay_pkg::DLY_W-1:0] step_s;
  logic [1:0] speed_q;
  logic delay_upd;
  logic err_q;

  assign step_s = $signed({32'h0000_0000, knob_step_ns});
  assign delay_upd = delay_load || knob_step || (speed_sel != speed_q);

  always_comb begin
    if (speed_sel == trig_delay_pkg::SPEED_1S) begin
      lim_pos = trig_delay_pkg::LIM_POS_1S;
      lim_neg = trig_delay_pkg::LIM_NEG_1S;
    end else begin
      lim_pos = trig_delay_pkg::LIM_POS_500NS;
      lim_neg = trig_delay_pkg::LIM_NEG_500NS;
    end
  end

  always_comb begin
    if (delay_load) begin
      delay_raw = delay_req;
    end else if (knob_step && knob_cw) begin
      delay_raw = delay_q - step_s;
    end else if (knob_step) begin
      delay_raw = delay_q + step_s;
    end else begin
      delay_raw = delay_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      speed_q <= trig_delay_pkg::SPEED_500NS;
      delay_q <= trig_delay_pkg::DELAY_RESET;
      err_q <= 1'b0;
    end else begin
      speed_q <= speed_sel;
      if (delay_upd && delay_raw > lim_pos) begin
        delay_q <= lim_pos;
        err_q <= 1'b1;
      end else if (delay_upd && delay_raw < -lim_neg) begin
        delay_q <= -lim_neg;
        err_q <= 1'b1;
      end else if (delay_upd) begin
        delay_q <= delay_raw;
        err_q <= 1'b0;
      end
    end
  end

  assign delay_value = delay_q;
  assign delay_err = err_q;
  assign window_pre = delay_q[trig_delay_pkg::DLY_W-1];

  // ---------------------------------------------------------------
  // window start, referenced to the generated trigger
  // ---------------------------------------------------------------
  logic win_busy_q;
  logic win_q;
  logic signed [trig_delay_pkg::DLY_W-1:0] acc_q;
  logic signed [trig_delay_pkg::DLY_W-1:0] acc_nx;

  assign acc_nx = acc_q + 64'sh0000_0000_0000_0028;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      win_busy_q <= 1'b0;
      win_q <= 1'b0;
      acc_q <= '0;
    end else if (trig_fire) begin
      // non-positive delay: window opened at or before the trigger
      win_busy_q <= (delay_q > 0);
      win_q <= (delay_q <= 0);
      acc_q <= '0;
    end else if (win_busy_q) begin
      acc_q <= acc_nx;
      win_q <= (acc_nx >= delay_q);
      win_busy_q <= (acc_nx < delay_q);
    end else begin
      win_q <= 1'b0;
    end
  end

  assign window_start = win_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_wait_over;
    state_q == ST_TIMING && wait_done && trig_mode == mode_q;
  endsequence

  sequence s_final_edge;
    state_q == ST_FIRE && edge_hit && trig_mode == mode_q;
  endsequence

  a_event_final_edge: assert property (
    (state_q == ST_COUNT && edge_hit && cnt_q == count_last) |=> trig_out && state_q == ST_ARM)
    else $error("event delay did not fire on final edge");

  a_count_restart: assert property (
    (state_q == ST_ARM && mode_q == trig_delay_pkg::MODE_EVENT && trig_mode == mode_q && qual_hit)
    |=> (state_q == ST_COUNT && cnt_q == '0))
    else $error("edge counter not restarted on qualify");

  a_wait_to_fire: assert property (
    s_wait_over |=> state_q == ST_FIRE && !trig_out)
    else $error("wait end did not arm final edge");

  a_time_then_edge: assert property (
    s_final_edge |=> trig_out && state_q == ST_ARM)
    else $error("time delay did not fire on next edge");

  a_no_early_trig: assert property (
    (state_q == ST_TIMING && trig_mode == mode_q)
    |=> !trig_out && (state_q == ST_TIMING || state_q == ST_FIRE))
    else $error("trigger during wait interval");

  a_wait_ignores_qual: assert property (
    (state_q == ST_TIMING && !wait_done && trig_mode == mode_q)
    |=> state_q == ST_TIMING && wait_q == $past(wait_q) + 32'h0000_0001)
    else $error("wait restarted before interval elapsed");

  a_auto_timeout: assert property (
    (auto_sweep && auto_cnt_q == trig_delay_pkg::AUTO_W'(AUTO_TIMEOUT_CYCLES - 1))
    |=> sweep_start ##1 (!sweep_start || trig_out))
    else $error("auto sweep did not start on timeout");

  a_trigd_sweep_only: assert property (
    (sweep_start && !$past(auto_sweep)) |-> $past(trig_fire))
    else $error("triggered mode swept without trigger");

  a_window_ref_trig: assert property (
    (trig_fire && delay_q <= 0) |=> window_start)
    else $error("non-positive delay window not at trigger");

  a_window_delayed: assert property (
    (trig_fire && delay_q > 0 && delay_q <= 64'sh0000_0000_0000_0028) |=> win_busy_q ##1 window_start)
    else $error("positive delay not counted from trigger");

  a_clamp_pos: assert property (
    (delay_upd && delay_raw > lim_pos) |=> delay_err && delay_q == $past(lim_pos))
    else $error("delay above limit not clamped");

  a_limits_hold: assert property (
    delay_upd |=> delay_q <= $past(lim_pos) && delay_q >= -$past(lim_neg))
    else $error("delay outside speed limits");

  a_knob_cw_down: assert property (
    (knob_step && knob_cw && !delay_load && knob_step_ns != '0 && delay_raw >= -lim_neg
     && delay_raw <= lim_pos) |=> delay_q < $past(delay_q))
    else $error("clockwise knob did not decrease delay");

endmodule

// *** trig_src_model.sv ***
// partner model: conditioned trigger source pulses
`timescale 1ns/1ps
module trig_src_model (
  // clock and request
  input wire logic ref_clk,
  input wire logic go,
  input wire logic [1:0] qsrc,
  input wire logic [1:0] esrc,
  input wire logic [3:0] n_edge,
  // conditioned trigger lines
  output logic [3:0] trig_in,
  output logic busy
);
  // pulses are 6 cycles wide and 6 apart, above the 2-cycle edge detect minimum
  task automatic pulse(input logic [1:0] s);
    trig_in[s] <= 1'b1;
    repeat (6) @(posedge ref_clk);
    trig_in[s] <= 1'b0;
    repeat (6) @(posedge ref_clk);
  endtask
  // one qualifier pulse, then a train of edge pulses; idle lines sit low
  initial begin
    trig_in = 4'h0;
    busy = 1'b0;
    forever begin
      @(posedge ref_clk);
      if (go) begin
        busy <= 1'b1;
        pulse(qsrc);
        repeat (n_edge) pulse(esrc);
        busy <= 1'b0;
      end
    end
  end
endmodule

// *** tb_top.sv ***
// testbench for the trigger delay qualifier
`timescale 1ns/1ps
module tb_top;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  typedef struct {logic [63:0] ex; logic er;} dnote_t;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] trig_in;
  logic [1:0] trig_mode = 2'h0, qual_src = 2'h0, edge_src = 2'h0, speed_sel = 2'h0;
  logic qual_neg = 1'b0, edge_neg = 1'b0, auto_sweep = 1'b0;
  logic [19:0] event_count = 20'h0_0001;
  logic [31:0] wait_cycles = 32'h0000_0001, knob_step_ns = 32'h0000_0000;
  logic signed [63:0] delay_req = 64'h0;
  logic delay_load = 1'b0, knob_step = 1'b0, knob_cw = 1'b0;
  logic trig_out, sweep_start, window_start, window_pre, delay_err, delay_busy;
  logic signed [63:0] delay_value;
  logic go = 1'b0, busy;
  logic [1:0] q_src = 2'h0, e_src = 2'h0;
  logic [3:0] n_edge = 4'h0;
  logic cur_en = 1'b0, prev_e = 1'b0, upd_q = 1'b0;
  int fail_count = 0, cmp_count = 0, sel_cnt = 0, since = 0, lag = 0, sw_cnt = 0;
  int tq[$];
  dnote_t dq[$];
  dnote_t de;

  always #20 ref_clk = ~ref_clk;

  trigger_delay_qualifier #(.AUTO_TIMEOUT_CYCLES(32'h0000_0040)) trigger_delay_qualifier_i (
    .ref_clk, .nrst, .trig_in, .trig_mode, .qual_src, .qual_neg, .edge_src, .edge_neg,
    .event_count, .wait_cycles, .auto_sweep, .speed_sel, .delay_req, .delay_load,
    .knob_step, .knob_cw, .knob_step_ns, .trig_out, .sweep_start, .window_start,
    .window_pre, .delay_value, .delay_err, .delay_busy);

  trig_src_model trig_src_model_i (
    .ref_clk, .go, .qsrc(q_src), .esrc(e_src), .n_edge, .trig_in, .busy);

  // ---------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // watcher: takes the oldest note whenever a result shows
  always @(posedge ref_clk) begin
    if (nrst) begin
      if (trig_in[e_src] !== prev_e && trig_in[e_src] === ~cur_en) sel_cnt++;
      prev_e = trig_in[e_src];
      if (upd_q) begin
        de = dq.pop_front();
        chk("delay_value", delay_value, de.ex);
        chk("delay_err", {63'h0, delay_err}, {63'h0, de.er});
        chk("window_pre", {63'h0, window_pre}, {63'h0, de.ex[63]});
      end
      upd_q = delay_load | knob_step;
      if (!auto_sweep) chk("sweep_start", {63'h0, sweep_start}, {63'h0, trig_out});
      if (trig_out === 1'b1) begin
        if (tq.size() == 0) chk("trig_out", 64'h1, 64'h0);
        else chk("edge_count", 64'(sel_cnt), 64'(tq.pop_front()));
        since = 0;
      end else begin
        since++;
      end
      if (window_start === 1'b1) chk("window_lag", 64'(since), 64'(lag));
      if (sweep_start === 1'b1) sw_cnt++;
    end
  end

  // ---------------------------------------------------------------
  // drivers
  // ---------------------------------------------------------------
  task automatic set_delay(input logic [1:0] sp, input logic [63:0] rq,
                           input logic [63:0] ex, input logic er);
    @(posedge ref_clk);
    speed_sel <= sp;
    @(posedge ref_clk);
    delay_req <= rq;
    delay_load <= 1'b1;
    dq.push_back('{ex, er});
    @(posedge ref_clk);
    delay_load <= 1'b0;
  endtask

  task automatic turn_knob(input logic cw, input logic [31:0] st, input logic [63:0] ex);
    @(posedge ref_clk);
    knob_step <= 1'b1;
    knob_cw <= cw;
    knob_step_ns <= st;
    dq.push_back('{ex, 1'b0});
    @(posedge ref_clk);
    knob_step <= 1'b0;
  endtask

  task automatic wait_done();
    int i;
    logic bz;
    i = 0;
    bz = 1'b0;
    @(posedge ref_clk);
    while (busy === 1'b1 && i < 3000) begin
      @(posedge ref_clk);
      bz = bz | delay_busy;
      i++;
    end
    repeat (40) @(posedge ref_clk);
    if (i >= 3000) begin
      fail_count++;
      give_verdict();
    end else begin
      chk("pending", 64'(tq.size()), 64'h0);
      chk("delay_busy", {63'h0, bz}, {63'h0, trig_mode != trig_delay_pkg::MODE_EDGE});
    end
  endtask

  task automatic run_row(input logic [1:0] md, input logic [1:0] qs, input logic qn,
                         input logic [1:0] es, input logic en, input logic [31:0] cnt,
                         input logic [3:0] n, input int ex, input logic [63:0] dly, input int lg);
    set_delay(2'h0, dly, dly, 1'b0);
    @(posedge ref_clk);
    trig_mode <= md;
    qual_src <= qs;
    qual_neg <= qn;
    edge_src <= es;
    edge_neg <= en;
    event_count <= cnt[19:0];
    wait_cycles <= cnt;
    q_src <= qs;
    e_src <= es;
    n_edge <= n;
    cur_en = en;
    lag = lg;
    sel_cnt = 0;
    if (md == trig_delay_pkg::MODE_EDGE) for (int k = 1; k <= n; k++) tq.push_back(k);
    else tq.push_back(ex);
    repeat (4) @(posedge ref_clk);
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    wait_done();
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [63:0] rq;
    void'($urandom(47220));
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk("delay_value", delay_value, 64'h0);
    chk("delay_busy", {63'h0, delay_busy}, 64'h0);
    chk("trig_out", {63'h0, trig_out}, 64'h0);
    $display("test reset done");
    set_delay(2'h0, trig_delay_pkg::LIM_POS_500NS, trig_delay_pkg::LIM_POS_500NS, 1'b0);
    set_delay(2'h0, trig_delay_pkg::LIM_POS_500NS + 64'h1, trig_delay_pkg::LIM_POS_500NS, 1'b1);
    set_delay(2'h0, -trig_delay_pkg::LIM_NEG_500NS - 64'h1, -trig_delay_pkg::LIM_NEG_500NS, 1'b1);
    set_delay(2'h1, trig_delay_pkg::LIM_POS_1S + 64'h1, trig_delay_pkg::LIM_POS_1S, 1'b1);
    set_delay(2'h1, -trig_delay_pkg::LIM_NEG_1S - 64'h1, -trig_delay_pkg::LIM_NEG_1S, 1'b1);
    set_delay(2'h2, trig_delay_pkg::LIM_POS_1S, trig_delay_pkg::LIM_POS_500NS, 1'b1);
    rq = 64'($urandom_range(32'h05F5_E100, 32'h0000_0000));
    set_delay(2'h0, rq, rq, 1'b0);
    set_delay(2'h0, 64'h0000_0000_0000_03E8, 64'h0000_0000_0000_03E8, 1'b0);
    turn_knob(1'b1, 32'h0000_0064, 64'h0000_0000_0000_0384);
    turn_knob(1'b0, 32'h0000_012C, 64'h0000_0000_0000_04B0);
    $display("test delay done");
    run_row(2'h1, 2'h0, 1'b1, 2'h1, 1'b0, 32'h0000_0003, 4'h5, 3, 64'h0, 0);
    run_row(2'h1, 2'h2, 1'b0, 2'h3, 1'b1, 32'h0000_0001, 4'h3, 1,
            64'hFFFF_FFFF_FFFF_FC18, 0);
    run_row(2'h2, 2'h0, 1'b1, 2'h1, 1'b0, 32'h0000_0024, 4'h6, 4, 64'h190, 10);
    run_row(2'h0, 2'h3, 1'b0, 2'h2, 1'b0, 32'h0000_0001, 4'h2, 0,
            64'h0000_0000_0000_0028, 1);
    $display("test trigger done");
    @(posedge ref_clk);
    auto_sweep <= 1'b1;
    sw_cnt = 0;
    repeat (650) @(posedge ref_clk);
    chk("auto_sweeps", 64'(sw_cnt), 64'hA);
    $display("test auto done");
    give_verdict();
  end
endmodule
